/* bench/tb_top.sv */
// Self-checking bench for the converter control register block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, h;
	logic [15:0] rf [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
	logic        pdv = 1'b0, pde = 1'b0, sense = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin_rd, on, route, just;
	logic [1:0]  bresp, rresp, sel;
	logic [8:0]  code, c;
	logic [15:0] lvl;
	logic [7:0]  ctl_m = 8'h00;
	int          fail_count = 0, cmp_count = 0, seed = 74730, code_m = 0;
	// 250 MHz clock
	always #2 aclk = ~aclk;
	dcr_top dcr_top_i (
		.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
		.s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
		.s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
		.s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
		.s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
		.supply_level(rf[0]), .opamp_output_level(rf[1]), .ref_pin_level(rf[2]),
		.fixed_reference_level(rf[3]), .port_drive_value(pdv), .port_drive_enable(pde),
		.pin_sense(sense), .level_output_pin_o(pin_o), .level_output_pin_oe(pin_oe),
		.pin_read_value(pin_rd), .converter_on(on), .level_pin_route(route),
		.code_justify_select(just), .top_reference_select(sel), .level_code(code),
		.level_output(lvl)
	);
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Bus write; ends one edge later so the next call never reassigns at the same edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1) && ++n < 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 50);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
		if (n >= 50)
		begin
			fail_count++;
			report_and_stop();
		end
		@(posedge aclk);
	endtask
	// Bus read with data and response compare
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1 && ++n < 50);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 50);
		chk(rdata, {24'h0, e});
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
		if (n >= 50)
		begin
			fail_count++;
			report_and_stop();
		end
		@(posedge aclk);
	endtask
	// Level and active code against the integer model; level lags by a cycle, so settle first
	task automatic chk_lvl;
		repeat (3) @(posedge aclk);
		chk({16'h0, lvl}, ctl_m[7] ? (32'(rf[ctl_m[3:2]]) * 32'(code_m)) >> 9 : 32'h0);
		chk({23'h0, code}, 32'(code_m));
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_lvl();
		rc(dcr_pkg::ADDR_CONTROL, 8'h00, dcr_pkg::RESP_OKAY);
		rc(dcr_pkg::ADDR_CODE_HIGH, 8'h00, dcr_pkg::RESP_OKAY);
		// Every source, both layouts, random unused and route bits
		for (int i = 0; i < 8; i++)
		begin
			h = $random(seed);
			rf[i % 4] <= h[31:16];
			{sense, pdv, pde} <= h[10:8];
			c = h[24:16];
			ctl_m = {1'b1, i[2], h[5:4], i[1:0], h[1:0]};
			wr(dcr_pkg::ADDR_CONTROL, ctl_m, 4'h1, dcr_pkg::RESP_OKAY);
			ctl_m = ctl_m & 8'hEC;
			rc(dcr_pkg::ADDR_CONTROL, ctl_m, dcr_pkg::RESP_OKAY);
			chk({27'h0, on, just, route, sel}, {27'h0, ctl_m[7:5], ctl_m[3:2]});
			chk({29'h0, pin_rd, pin_oe, pin_o}, ctl_m[5] ? 32'h0 : {29'h0, sense, pde, pdv});
			wr(dcr_pkg::ADDR_CODE_LOW, i[2] ? c[7:0] : {c[0], h[30:24]}, 4'h1, dcr_pkg::RESP_OKAY);
			chk_lvl();
			wr(dcr_pkg::ADDR_CODE_HIGH, i[2] ? {h[14:8], c[8]} : c[8:1], 4'h1, dcr_pkg::RESP_OKAY);
			code_m = 32'(c);
			chk_lvl();
			rc(dcr_pkg::ADDR_CODE_HIGH, i[2] ? {7'h0, c[8]} : c[8:1], dcr_pkg::RESP_OKAY);
			rc(dcr_pkg::ADDR_CODE_LOW, i[2] ? c[7:0] : {c[0], 7'h0}, dcr_pkg::RESP_OKAY);
		end
		// Software switches off before going idle
		ctl_m = ctl_m & 8'h7F;
		wr(dcr_pkg::ADDR_CONTROL, ctl_m, 4'h1, dcr_pkg::RESP_OKAY);
		chk_lvl();
		repeat (20) @(posedge aclk);
		rc(dcr_pkg::ADDR_CONTROL, ctl_m, dcr_pkg::RESP_OKAY);
		// Unmapped place and a write with its byte strobe off
		wr(4'hC, 8'hFF, 4'h1, dcr_pkg::RESP_SLVERR);
		rc(4'hC, 8'h00, dcr_pkg::RESP_SLVERR);
		wr(dcr_pkg::ADDR_CONTROL, 8'hFF, 4'h0, dcr_pkg::RESP_OKAY);
		rc(dcr_pkg::ADDR_CONTROL, ctl_m, dcr_pkg::RESP_OKAY);
		// Reset in mid-run with the converter on and routed
		wr(dcr_pkg::ADDR_CONTROL, 8'hA0, 4'h1, dcr_pkg::RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		ctl_m = 8'h00;
		code_m = 0;
		chk_lvl();
		chk({30'h0, on, route}, 32'h0);
		rc(dcr_pkg::ADDR_CODE_HIGH, 8'h00, dcr_pkg::RESP_OKAY);
		report_and_stop();
	end
endmodule
`default_nettype wire

/* verilog/dcr_pkg.sv */
// Constants for the converter control register block
`default_nettype none
package dcr_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL   = 4'h0;
	localparam logic [3:0] ADDR_CODE_HIGH = 4'h4;
	localparam logic [3:0] ADDR_CODE_LOW  = 4'h8;
	// ------------------------------------------------------------
	// Control field positions and reset values
	// ------------------------------------------------------------
	localparam int         CTL_ON_BIT     = 7;
	localparam int         CTL_JUST_BIT   = 6;
	localparam int         CTL_ROUTE_BIT  = 5;
	localparam int         CTL_SEL_LSB    = 2;
	localparam logic [7:0] CTL_WMASK      = 8'hEC;
	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [7:0] CODE_RESET     = 8'h00;
	localparam int         CODE_W         = 9;
	localparam int         CODE_SHIFT     = 9;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	// Top reference sources
	typedef enum logic [1:0] {
		DCR_SRC_SUPPLY = 2'h0,
		DCR_SRC_OPAMP  = 2'h1,
		DCR_SRC_PIN    = 2'h2,
		DCR_SRC_FIXED  = 2'h3
	} dcr_src_t;
endpackage
`default_nettype wire

/* verilog/dcr_top.sv */
// Converter control registers with AXI4-Lite slave and level computation
`default_nettype none
module dcr_top #(
	parameter int REF_W = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [3:0]        s_axil_awaddr,
	input  wire logic              s_axil_awvalid,
	output logic                   s_axil_awready,
	input  wire logic [31:0]       s_axil_wdata,
	input  wire logic [3:0]        s_axil_wstrb,
	input  wire logic              s_axil_wvalid,
	output logic                   s_axil_wready,
	output logic [1:0]             s_axil_bresp,
	output logic                   s_axil_bvalid,
	input  wire logic              s_axil_bready,
	input  wire logic [3:0]        s_axil_araddr,
	input  wire logic              s_axil_arvalid,
	output logic                   s_axil_arready,
	output logic [31:0]            s_axil_rdata,
	output logic [1:0]             s_axil_rresp,
	output logic                   s_axil_rvalid,
	input  wire logic              s_axil_rready,
	input  wire logic [REF_W-1:0]  supply_level,
	input  wire logic [REF_W-1:0]  ref_pin_level,
	input  wire logic [REF_W-1:0]  opamp_output_level,
	input  wire logic [REF_W-1:0]  fixed_reference_level,
	input  wire logic              port_drive_value,
	input  wire logic              port_drive_enable,
	input  wire logic              pin_sense,
	output logic                   level_output_pin_o,
	output logic                   level_output_pin_oe,
	output logic                   pin_read_value,
	output logic                   converter_on,
	output logic                   level_pin_route,
	output logic                   code_justify_select,
	output logic [1:0]             top_reference_select,
	output logic [8:0]             level_code,
	output logic [REF_W-1:0]       level_output
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0]       control_q;
	logic [7:0]       code_high_q;
	logic [7:0]       code_low_q;
	logic [8:0]       level_code_q;
	logic [REF_W-1:0] level_q;
	logic [REF_W-1:0] ref_sel;
	logic [REF_W+8:0] product;
	logic             wr_go;
	logic             wr_hit;
	logic             rd_go;
	logic [7:0]       rd_byte;
	logic             rd_hit;
	logic [7:0]       wbyte;
	logic             just_right;
	logic [8:0]       code_from_write;

	assign just_right           = control_q[dcr_pkg::CTL_JUST_BIT];
	assign converter_on         = control_q[dcr_pkg::CTL_ON_BIT];
	assign level_pin_route      = control_q[dcr_pkg::CTL_ROUTE_BIT];
	assign code_justify_select  = just_right;
	assign top_reference_select = control_q[dcr_pkg::CTL_SEL_LSB +: 2];
	assign level_code           = level_code_q;
	assign level_output         = level_q;
	assign wbyte                = s_axil_wdata[7:0];

	// ------------------------------------------------------------
	// Write channel: both address and data taken in one edge
	// ------------------------------------------------------------
	// Waiting for both keeps one write in flight without extra holding registers
	assign s_axil_awready = s_axil_awvalid && s_axil_wvalid && !s_axil_bvalid;
	assign s_axil_wready  = s_axil_awready;
	assign wr_go          = s_axil_awready;
	assign wr_hit         = (s_axil_awaddr == dcr_pkg::ADDR_CONTROL)
		|| (s_axil_awaddr == dcr_pkg::ADDR_CODE_HIGH)
		|| (s_axil_awaddr == dcr_pkg::ADDR_CODE_LOW);

	// Write response one cycle after the take
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= dcr_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp  <= wr_hit ? dcr_pkg::RESP_OKAY : dcr_pkg::RESP_SLVERR;
		end
		else if (s_axil_bready)
			s_axil_bvalid <= 1'b0;
	end

	// Control register: only reset or a bus write to it with byte strobe 0 set changes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			control_q <= dcr_pkg::CONTROL_RESET;
		else if (wr_go && s_axil_wstrb[0] && s_axil_awaddr == dcr_pkg::ADDR_CONTROL)
			control_q <= wbyte & dcr_pkg::CTL_WMASK;
	end

	// Staged byte pair; unused bits of the current layout are dropped at write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			code_high_q <= dcr_pkg::CODE_RESET;
			code_low_q  <= dcr_pkg::CODE_RESET;
		end
		else if (wr_go && s_axil_wstrb[0])
		begin
			if (s_axil_awaddr == dcr_pkg::ADDR_CODE_HIGH)
				code_high_q <= just_right ? {7'h00, wbyte[0]} : wbyte;
			if (s_axil_awaddr == dcr_pkg::ADDR_CODE_LOW)
				code_low_q <= just_right ? wbyte : {wbyte[7], 7'h00};
		end
	end

	// Active code assembled from the new high byte and the staged low byte
	always_comb
	begin
		if (just_right)
			code_from_write = {wbyte[0], code_low_q};
		else
			code_from_write = {wbyte, code_low_q[7]};
	end

	// Low written first; active code changes only when the high write lands
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			level_code_q <= 9'h000;
		else if (wr_go && s_axil_wstrb[0] && s_axil_awaddr == dcr_pkg::ADDR_CODE_HIGH)
			level_code_q <= code_from_write;
	end

	// ------------------------------------------------------------
	// Level computation
	// ------------------------------------------------------------
	always_comb
	begin
		case (top_reference_select)
			dcr_pkg::DCR_SRC_FIXED:  ref_sel = fixed_reference_level;
			dcr_pkg::DCR_SRC_PIN:    ref_sel = ref_pin_level;
			dcr_pkg::DCR_SRC_OPAMP:  ref_sel = opamp_output_level;
			dcr_pkg::DCR_SRC_SUPPLY: ref_sel = supply_level;
			default:                 ref_sel = supply_level;
		endcase
	end

	assign product = ref_sel * level_code_q;

	// Divide by 512 steps; a disabled converter outputs zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			level_q <= '0;
		else if (converter_on)
			level_q <= product[dcr_pkg::CODE_SHIFT +: REF_W];
		else
			level_q <= '0;
	end

	// ------------------------------------------------------------
	// Output pin: analog route overrides digital driver and sense
	// ------------------------------------------------------------
	assign level_output_pin_o  = level_pin_route ? 1'b0 : port_drive_value;
	assign level_output_pin_oe = !level_pin_route && port_drive_enable;
	assign pin_read_value      = level_pin_route ? 1'b0 : pin_sense;

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign s_axil_arready = !s_axil_rvalid;
	assign rd_go          = s_axil_arvalid && s_axil_arready;

	always_comb
	begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (s_axil_araddr)
			dcr_pkg::ADDR_CONTROL:   rd_byte = control_q;
			dcr_pkg::ADDR_CODE_HIGH: rd_byte = code_high_q;
			dcr_pkg::ADDR_CODE_LOW:  rd_byte = code_low_q;
			default:                 rd_hit  = 1'b0;
		endcase
	end

	// Read data one cycle after the take, held until accepted
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= 32'h00000000;
			s_axil_rresp  <= dcr_pkg::RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata  <= {24'h000000, rd_byte};
			s_axil_rresp  <= rd_hit ? dcr_pkg::RESP_OKAY : dcr_pkg::RESP_SLVERR;
		end
		else if (s_axil_rready)
			s_axil_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic ctl_write;
	logic high_write;
	assign ctl_write  = wr_go && s_axil_awaddr == dcr_pkg::ADDR_CONTROL;
	assign high_write = wr_go && s_axil_wstrb[0] && s_axil_awaddr == dcr_pkg::ADDR_CODE_HIGH;

	sequence s_write_taken;
		wr_go;
	endsequence
	// Response code must match whether the taken address was mapped
	sequence s_resp_shown;
		s_axil_bvalid
			&& s_axil_bresp == ($past(wr_hit) ? dcr_pkg::RESP_OKAY : dcr_pkg::RESP_SLVERR);
	endsequence

	a_ctl_hold_nowrite: assert property (!ctl_write |=> $stable(control_q))
		else $error("control changed without a write");
	a_reserved_zero: assert property ((control_q & ~dcr_pkg::CTL_WMASK) == 8'h00)
		else $error("reserved control bits not zero");
	a_code_load_high: assert property (!high_write |=> $stable(level_code_q))
		else $error("code changed without high write");
	a_code_after_high: assert property (high_write |=> level_code_q == $past(code_from_write))
		else $error("code not loaded from high write");
	a_pin_read_zero: assert property (level_pin_route |-> !pin_read_value && !level_output_pin_oe)
		else $error("routed pin not overridden");
	a_off_out_zero: assert property (!converter_on |=> level_q == '0)
		else $error("level nonzero while off");
	a_write_resp: assert property (s_write_taken |=> s_resp_shown)
		else $error("write response late");
	a_read_resp: assert property (rd_go |=> s_axil_rvalid && s_axil_rdata[31:8] == 24'h000000)
		else $error("read response late or wide");
	a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> control_q == 8'h00 && level_code_q == 9'h000)
		else $error("reset did not clear state");
endmodule
`default_nettype wire
